// [design/ast_transceiver.sv]
`timescale 1ns/1ns
// Behaviour
// R1: idle line at mark, NRZ data bits
// R2: frame is start, 8/9 data, stop
// R3: every transmitted bit lasts one bit period
// R4: 8- or 16-bit divider sets bit timing
// R5: data shifted least significant bit first
// R6: both directions share format and rate
// R7: no parity; ninth bit carried plainly
// R8: shift register loaded only from holding buffer
// R9: transmit needs enable, async mode, port on
// R10: port enable drives transmit pin output
// R11: empty flag sets when transmit enabled
// R12: holding write starts send, moves if idle
// R13: queued char moves after stop, start follows
// R14: polarity invert flips idle and data
// R15: empty flag clear only busy and queued; code also clears it while transmit is off
// R16: empty flag valid two cycles after write
// R17: empty flag is read-only
// R18: interrupt gated by enable, flag not
// R19: receive sampled at sixteen times baud
// R20: complete character enters two-entry FIFO
// R21: received data only via data register read
// R22: receive needs enable, async mode, port on
// R23: false start abandoned without error
// R24: mid-bit majority vote per data bit
// R25: zero stop sample sets framing error
// R26: data-available flag set while FIFO holds char; code also clears it while receive is off
// R27: overrun on full FIFO blocks reception
module ast_transceiver (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // configuration
  input  wire ast_pkg::ast_cfg_t     cfg_i,
  input  wire logic [15:0]           baud_divisor_i,
  input  wire logic                  tx_irq_enable_i,
  // transmit holding buffer write
  input  wire logic                  tx_write_i,
  input  wire logic [8:0]            tx_data_i,
  // receive data register read
  input  wire logic                  rx_read_i,
  output logic [8:0]                 rx_data_o,
  output logic                       rx_framing_error_o,
  input  wire logic                  overrun_clear_i,
  // status
  output logic                       transmit_buffer_empty_flag_o,
  output logic                       tx_irq_o,
  output logic                       receive_data_available_flag_o,
  output logic                       overrun_o,
  output logic                       tx_busy_o,
  // pins
  output logic                       transmit_pin_o,
  output logic                       transmit_pin_oe_o,
  input  wire logic                  receive_pin_i
);

  logic tx_on;
  logic rx_on;
  assign tx_on = cfg_i.transmit_enable & ~cfg_i.clocked_mode_select & cfg_i.serial_port_enable; // see R9
  assign rx_on = cfg_i.receive_continuous_enable & ~cfg_i.clocked_mode_select
               & cfg_i.serial_port_enable; // see R22

  // one shared 16x tick keeps both directions at the same rate
  logic [15:0] div_cnt_q;
  logic [15:0] div_limit;
  logic        os_tick;
  assign div_limit = cfg_i.wide_divisor ? baud_divisor_i : {8'h00, baud_divisor_i[7:0]}; // see R4
  // compare with >= so a divisor lowered mid-count cannot wrap the counter for 65k clocks
  assign os_tick   = (div_cnt_q >= div_limit);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_q <= ast_pkg::DIVISOR_RESET;
    end else if (!cfg_i.serial_port_enable || os_tick) begin
      div_cnt_q <= ast_pkg::DIVISOR_RESET; // see R4 R6
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  logic [3:0] data_bits;
  assign data_bits = cfg_i.nine_bit_mode ? ast_pkg::DATA_BITS_9 : ast_pkg::DATA_BITS_8; // see R6 R7

  // ---------------- transmitter ----------------
  ast_pkg::ast_tx_state_t tx_state_q;
  logic [8:0] hold_q;
  logic       hold_full_q;
  logic [8:0] shift_q;
  logic [3:0] tx_os_q;
  logic [3:0] tx_bit_q;
  logic       tx_line_q;
  logic       tx_bit_end;
  logic       load_shift;
  logic       tx_idle;

  assign tx_bit_end = os_tick && (tx_os_q == ast_pkg::SAMPLE_LAST); // see R3
  assign tx_idle    = (tx_state_q == ast_pkg::AST_TX_IDLE);
  // idle shift register takes the queued char; after stop that is the next cycle
  assign load_shift = tx_on && hold_full_q && tx_idle; // see R8 R12 R13

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else if (!tx_on) begin
      hold_full_q <= 1'b0;
    end else if (tx_write_i) begin
      hold_q      <= tx_data_i; // see R12
      hold_full_q <= 1'b1;
    end else if (load_shift) begin
      hold_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= ast_pkg::AST_TX_IDLE;
      shift_q    <= ast_pkg::TX_SHIFT_RESET;
      tx_os_q    <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_line_q  <= 1'b1;
    end else if (!tx_on) begin
      tx_state_q <= ast_pkg::AST_TX_IDLE;
      tx_line_q  <= 1'b1; // see R1
    end else begin
      if (os_tick) begin
        tx_os_q <= tx_os_q + 4'h1;
      end
      unique case (tx_state_q)
        ast_pkg::AST_TX_IDLE: begin
          tx_line_q <= 1'b1; // see R1
          if (load_shift) begin
            shift_q    <= hold_q; // see R8
            tx_state_q <= ast_pkg::AST_TX_START;
            tx_line_q  <= 1'b0; // see R2 R13
            tx_os_q    <= 4'h0;
          end
        end
        ast_pkg::AST_TX_START: begin
          if (tx_bit_end) begin
            tx_state_q <= ast_pkg::AST_TX_DATA;
            tx_line_q  <= shift_q[0]; // see R5
            shift_q    <= {1'b1, shift_q[8:1]};
            tx_bit_q   <= 4'h1;
          end
        end
        ast_pkg::AST_TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit_q == data_bits) begin
              tx_state_q <= ast_pkg::AST_TX_STOP;
              tx_line_q  <= 1'b1; // see R2
            end else begin
              tx_line_q <= shift_q[0]; // see R1 R5
              shift_q   <= {1'b1, shift_q[8:1]};
              tx_bit_q  <= tx_bit_q + 4'h1;
            end
          end
        end
        ast_pkg::AST_TX_STOP: begin
          if (tx_bit_end) begin
            tx_state_q <= ast_pkg::AST_TX_IDLE; // see R13
          end
        end
      endcase
    end
  end

  // flag lags a write by one register so it settles on the second cycle
  logic tbe_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tbe_q <= 1'b0;
    end else begin
      tbe_q <= tx_on && !(hold_full_q && !load_shift); // see R11 R15 R16 R17
    end
  end

  assign transmit_buffer_empty_flag_o = tbe_q; // see R18
  assign tx_irq_o          = tbe_q & tx_irq_enable_i; // see R18
  assign tx_busy_o         = ~tx_idle;
  assign transmit_pin_o    = tx_line_q ^ (cfg_i.tx_polarity_invert & ~cfg_i.clocked_mode_select); // see R14
  assign transmit_pin_oe_o = cfg_i.serial_port_enable; // see R10

  // ---------------- receiver ----------------
  logic [1:0] rx_sync_q;
  logic [2:0] vote_q;
  logic       rx_bit;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sync_q <= ast_pkg::RX_SYNC_RESET;
    end else begin
      rx_sync_q <= {rx_sync_q[0], receive_pin_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vote_q <= ast_pkg::RX_VOTE_RESET;
    end else if (os_tick) begin
      vote_q <= {vote_q[1:0], rx_sync_q[1]}; // see R19
    end
  end
  // last three 16x samples, the newest taken just before bit centre
  assign rx_bit = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]); // see R24

  ast_pkg::ast_rx_state_t rx_state_q;
  logic [3:0] rx_os_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_shift_q;
  logic       rx_done;
  logic       rx_fe;
  logic       rx_mid;
  logic       overrun_q;
  assign rx_mid = os_tick && (rx_os_q == ast_pkg::SAMPLE_MID);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_q <= ast_pkg::AST_RX_HUNT;
      rx_os_q    <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_done    <= 1'b0;
      rx_fe      <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (os_tick) begin
        rx_os_q <= rx_os_q + 4'h1;
      end
      if (!rx_on) begin
        rx_state_q <= ast_pkg::AST_RX_HUNT;
      end else begin
        unique case (rx_state_q)
          ast_pkg::AST_RX_HUNT: begin
            // a low sample counts only after a high one, so a low stop bit starts no phantom frame
            if (os_tick && vote_q[0] && !rx_sync_q[1] && !overrun_q) begin
              rx_state_q <= ast_pkg::AST_RX_START; // see R27
              rx_os_q    <= 4'h1;
            end
          end
          ast_pkg::AST_RX_START: begin
            if (rx_mid) begin
              if (rx_bit) begin
                rx_state_q <= ast_pkg::AST_RX_HUNT; // see R23
              end else begin
                rx_state_q <= ast_pkg::AST_RX_DATA;
                rx_bit_q   <= 4'h0;
              end
            end
          end
          ast_pkg::AST_RX_DATA: begin
            if (rx_mid) begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if (cfg_i.nine_bit_mode) begin
                rx_shift_q <= {rx_bit, rx_shift_q[8:1]}; // see R5
              end else begin
                rx_shift_q <= {1'b0, rx_bit, rx_shift_q[7:1]}; // see R5
              end
              if (rx_bit_q + 4'h1 == data_bits) begin
                rx_state_q <= ast_pkg::AST_RX_STOP;
              end
            end
          end
          ast_pkg::AST_RX_STOP: begin
            if (rx_mid) begin
              rx_fe      <= ~rx_bit; // see R25
              rx_done    <= 1'b1; // see R20
              rx_state_q <= ast_pkg::AST_RX_HUNT;
            end
          end
        endcase
      end
    end
  end

  // two-entry buffer; producer ready is FIFO not full, consumer is the read strobe
  ast_pkg::ast_rx_char_t fifo_q [ast_pkg::FIFO_DEPTH];
  logic [1:0] count_q;
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic       fifo_ready;
  logic       fifo_valid;
  logic       push;
  logic       pop;
  assign fifo_ready = (count_q != 2'h2);
  assign fifo_valid = (count_q != 2'h0);
  assign pop  = rx_read_i && fifo_valid; // see R21
  assign push = rx_done && (fifo_ready || pop) && !overrun_q; // see R20

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q  <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= '{framing_error: rx_fe, data: rx_shift_q};
        wr_ptr_q         <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // set wins over clear so an overrun in the clearing cycle survives
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_q <= 1'b0;
    end else if (rx_done && !fifo_ready && !pop) begin
      overrun_q <= 1'b1; // see R27
    end else if (overrun_clear_i || !rx_on) begin
      overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_o          <= 9'h000;
      rx_framing_error_o <= 1'b0;
    end else if (pop) begin
      rx_data_o          <= fifo_q[rd_ptr_q].data; // see R21
      rx_framing_error_o <= fifo_q[rd_ptr_q].framing_error;
    end
  end

  assign receive_data_available_flag_o = rx_on && fifo_valid; // see R26
  assign overrun_o = overrun_q;

  // ---------------- checks ----------------
  chk_idle_mark: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    tx_idle && !load_shift |=> tx_line_q) else $error("line not at mark while idle");
  chk_port_drive: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    transmit_pin_oe_o == cfg_i.serial_port_enable) else $error("pin enable wrong");
  chk_start_space: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    load_shift |=> !tx_line_q && tx_state_q == ast_pkg::AST_TX_START) else $error("no start bit");
  chk_tbe_set: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    $rose(tx_on) |=> ##1 tbe_q) else $error("empty flag not set");
  chk_tbe_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see R15
    tx_on && hold_full_q && !tx_idle ##1 hold_full_q |-> !tbe_q) else $error("empty flag wrong");
  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see R18
    !tx_irq_enable_i |-> !tx_irq_o) else $error("irq not gated");
  chk_no_tx_off: assert property (@(posedge clk_i) disable iff (rst_i) // see R9
    !tx_on |=> tx_idle && !tbe_q) else $error("transmit active while off");
  sequence s_false_start;
    rx_state_q == ast_pkg::AST_RX_START && rx_mid && rx_bit;
  endsequence
  chk_false_start: assert property (@(posedge clk_i) disable iff (rst_i) // see R23
    s_false_start |=> rx_state_q == ast_pkg::AST_RX_HUNT && !rx_done) else $error("false start kept");
  chk_hunt_edge: assert property (@(posedge clk_i) disable iff (rst_i) // see R23
    rx_state_q == ast_pkg::AST_RX_HUNT && os_tick && !vote_q[0] |=> rx_state_q == ast_pkg::AST_RX_HUNT)
    else $error("start taken without falling edge");
  chk_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i) // see R20
    count_q <= 2'h2) else $error("fifo over depth");
  chk_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i) // see R27
    rx_done && !fifo_ready && !pop |=> overrun_q) else $error("overrun missed");
  chk_rda_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see R26
    push && rx_on |=> receive_data_available_flag_o) else $error("data flag not set");

endmodule : ast_transceiver

// [design/ast_pkg.sv]
package ast_pkg;
  // bit timing: 16x tick = clk / (divisor + 1); one bit lasts 16 ticks
  localparam int unsigned OVERSAMPLE      = 16;
  localparam logic [3:0]  SAMPLE_LAST     = 4'hF;
  localparam logic [3:0]  SAMPLE_MID      = 4'h7;
  localparam logic [3:0]  DATA_BITS_8     = 4'h8;
  localparam logic [3:0]  DATA_BITS_9     = 4'h9;
  localparam logic [15:0] DIVISOR_RESET   = 16'h0000;
  localparam logic [8:0]  TX_SHIFT_RESET  = 9'h1FF;
  localparam logic [1:0]  RX_SYNC_RESET   = 2'h3;
  localparam logic [2:0]  RX_VOTE_RESET   = 3'h7;
  localparam int unsigned FIFO_DEPTH      = 2;

  // transmit states in frame order: idle, start bit, data bits, stop bit
  typedef enum logic [1:0] {
    AST_TX_IDLE  = 2'b00,
    AST_TX_START = 2'b01,
    AST_TX_DATA  = 2'b11,
    AST_TX_STOP  = 2'b10
  } ast_tx_state_t;

  typedef enum logic [1:0] {
    AST_RX_HUNT  = 2'b00,
    AST_RX_START = 2'b01,
    AST_RX_DATA  = 2'b11,
    AST_RX_STOP  = 2'b10
  } ast_rx_state_t;

  // one received character with its framing status
  typedef struct packed {
    logic       framing_error;
    logic [8:0] data;
  } ast_rx_char_t;

  typedef struct packed {
    logic serial_port_enable;
    logic clocked_mode_select;
    logic transmit_enable;
    logic receive_continuous_enable;
    logic nine_bit_mode;
    logic tx_polarity_invert;
    logic wide_divisor;
  } ast_cfg_t;
endpackage : ast_pkg

// [sim/ast_remote_node.sv]
`timescale 1ns/1ns
module ast_remote_node #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input  wire logic clk_i,
  // serial line, one wire each way
  input  wire logic line_i,
  output logic      line_o
);
  // the wire is pulled up, so it rests at mark between frames
  initial line_o = 1'b1;

  task automatic hold_line(input logic lvl, input int clks);
    line_o <= lvl;
    repeat (clks) @(posedge clk_i);
  endtask : hold_line

  // a stop level of zero is used only to provoke a framing fault
  task automatic send_char(input logic [8:0] data, input int nbits, input logic stop_lvl);
    @(posedge clk_i);
    hold_line(1'b0, BIT_CLKS);
    for (int i = 0; i < nbits; i++) begin
      hold_line(data[i], BIT_CLKS);
    end
    hold_line(stop_lvl, BIT_CLKS);
    line_o <= 1'b1;
  endtask : send_char

  task automatic glitch(input int clks);
    @(posedge clk_i);
    hold_line(1'b0, clks);
    line_o <= 1'b1;
  endtask : glitch

  // samples at bit centres; waited reports how long the line idled first
  task automatic recv_char(input int nbits, output logic [8:0] data, output logic ok, output int waited);
    data = '0;
    waited = 0;
    while (line_i !== 1'b0 && waited < 20 * BIT_CLKS) begin
      @(posedge clk_i);
      waited++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    ok = (line_i === 1'b0);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      data[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    ok = ok && (line_i === 1'b1);
  endtask : recv_char
endmodule : ast_remote_node

// [sim/ast_transceiver_bench.sv]
`timescale 1ns/1ns
module ast_transceiver_bench;
  // divisor low byte 1 with the narrow divider gives 16*2 clocks per bit
  localparam int BIT_CLKS = 32;
  logic              clk_i           = 1'b0;
  logic              rst_i           = 1'b1;
  ast_pkg::ast_cfg_t cfg_i           = '0;
  logic [15:0]       baud_divisor_i  = 16'h0101;
  logic              tx_irq_enable_i = 1'b0;
  logic              tx_write_i      = 1'b0;
  logic [8:0]        tx_data_i       = 9'h000;
  logic              rx_read_i       = 1'b0;
  logic              overrun_clear_i = 1'b0;
  logic [8:0]        rx_data_o;
  logic              rx_framing_error_o;
  logic              tbe_o;
  logic              tx_irq_o;
  logic              avail_o;
  logic              overrun_o;
  logic              tx_busy_o;
  logic              pin_o;
  logic              pin_oe_o;
  logic              rx_pin;
  logic [8:0]        got;
  logic              ok;
  int                waited;
  int                error_cnt = 0;
  int                n_checks  = 0;

  always #2 clk_i = ~clk_i;

  ast_transceiver u_ast_transceiver (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .baud_divisor_i(baud_divisor_i),
    .tx_irq_enable_i(tx_irq_enable_i), .tx_write_i(tx_write_i), .tx_data_i(tx_data_i),
    .rx_read_i(rx_read_i), .rx_data_o(rx_data_o), .rx_framing_error_o(rx_framing_error_o),
    .overrun_clear_i(overrun_clear_i), .transmit_buffer_empty_flag_o(tbe_o), .tx_irq_o(tx_irq_o),
    .receive_data_available_flag_o(avail_o), .overrun_o(overrun_o), .tx_busy_o(tx_busy_o),
    .transmit_pin_o(pin_o), .transmit_pin_oe_o(pin_oe_o), .receive_pin_i(rx_pin)
  );

  ast_remote_node #(.BIT_CLKS(BIT_CLKS)) u_ast_remote_node (
    .clk_i(clk_i), .line_i(pin_o), .line_o(rx_pin)
  );

  task automatic chk(input logic [8:0] got_v, input logic [8:0] exp_v, input string what);
    n_checks++;
    if (got_v !== exp_v) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // bit order: port, clocked, tx, rx, nine, invert, wide; flags valid two edges on
  task automatic set_cfg(input logic [6:0] v);
    @(posedge clk_i);
    cfg_i <= ast_pkg::ast_cfg_t'(v);
    settle(2);
  endtask : set_cfg

  task automatic write_tx(input logic [8:0] d);
    @(posedge clk_i);
    tx_write_i <= 1'b1;
    tx_data_i  <= d;
    @(posedge clk_i);
    tx_write_i <= 1'b0;
  endtask : write_tx

  task automatic read_rx(input logic [8:0] d, input logic fe);
    chk(avail_o, 1'b1, "data available");
    @(posedge clk_i);
    rx_read_i <= 1'b1;
    @(posedge clk_i);
    rx_read_i <= 1'b0;
    settle(1);
    chk(rx_data_o, d, "received data");
    chk(rx_framing_error_o, fe, "framing error");
  endtask : read_rx

  task automatic send_ok(input logic [8:0] d);
    u_ast_remote_node.send_char(d, 8, 1'b1);
    settle(1);
  endtask : send_ok

  task automatic results();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk(pin_o, 1'b1, "idle mark");
    chk(pin_oe_o, 1'b0, "pin not driven");
    set_cfg(7'h70);
    chk(pin_oe_o, 1'b1, "pin driven");
    write_tx(9'h0A5);
    settle(2);
    chk(tbe_o, 1'b0, "clocked mode flag");
    chk(tx_busy_o, 1'b0, "clocked mode idle");
    set_cfg(7'h58);
    chk(tbe_o, 1'b1, "flag on enable");
    chk(tx_irq_o, 1'b0, "irq masked");
    @(posedge clk_i);
    tx_irq_enable_i <= 1'b1;
    settle(1);
    chk(tx_irq_o, 1'b1, "irq unmasked");
    fork
      begin
        u_ast_remote_node.recv_char(8, got, ok, waited);
        chk(got, 9'h0A5, "first char");
        chk(ok, 1'b1, "first framing");
        u_ast_remote_node.recv_char(8, got, ok, waited);
        chk(got, 9'h05A, "queued char");
        chk(ok, 1'b1, "queued framing");
        chk(waited <= BIT_CLKS / 2 + 4, 1'b1, "start follows stop");
      end
      begin
        write_tx(9'h0A5);
        settle(4);
        chk(tx_busy_o, 1'b1, "shifting");
        write_tx(9'h05A);
        settle(2);
        chk(tbe_o, 1'b0, "flag while queued");
        chk(tx_irq_o, 1'b0, "irq while queued");
      end
    join
    settle(BIT_CLKS);
    chk(tbe_o, 1'b1, "flag after drain");
    set_cfg(7'h5C);
    fork
      u_ast_remote_node.recv_char(9, got, ok, waited);
      write_tx(9'h1A5);
    join
    chk(got, 9'h1A5, "nine bit tx");
    u_ast_remote_node.send_char(9'h15A, 9, 1'b1);
    settle(1);
    read_rx(9'h15A, 1'b0);
    set_cfg(7'h58);
    send_ok(9'h03C);
    read_rx(9'h03C, 1'b0);
    u_ast_remote_node.send_char(9'h0C3, 8, 1'b0);
    settle(BIT_CLKS);
    read_rx(9'h0C3, 1'b1);
    u_ast_remote_node.glitch(BIT_CLKS / 4);
    settle(12 * BIT_CLKS);
    chk(avail_o, 1'b0, "false start dropped");
    chk(overrun_o, 1'b0, "no overrun yet");
    send_ok(9'h011);
    send_ok(9'h022);
    send_ok(9'h033);
    chk(overrun_o, 1'b1, "third char overruns");
    read_rx(9'h011, 1'b0);
    read_rx(9'h022, 1'b0);
    chk(avail_o, 1'b0, "fifo drained");
    send_ok(9'h055);
    chk(avail_o, 1'b0, "blocked while overrun");
    @(posedge clk_i);
    overrun_clear_i <= 1'b1;
    @(posedge clk_i);
    overrun_clear_i <= 1'b0;
    settle(1);
    chk(overrun_o, 1'b0, "overrun cleared");
    send_ok(9'h044);
    read_rx(9'h044, 1'b0);
    // wide divider uses all 16 divisor bits: 258 clocks per tick keeps the start bit far longer
    set_cfg(7'h59);
    write_tx(9'h0F0);
    settle(40 * BIT_CLKS);
    chk(pin_o, 1'b0, "wide divisor start bit");
    set_cfg(7'h48);
    chk(tx_busy_o, 1'b0, "transmit off idles");
    chk(pin_o, 1'b1, "mark after abort");
    set_cfg(7'h58);
    chk(tbe_o, 1'b1, "flag on re-enable");
    set_cfg(7'h5A);
    chk(pin_o, 1'b0, "inverted idle");
    set_cfg(7'h58);
    chk(pin_o, 1'b1, "normal idle");
    results();
  end
endmodule : ast_transceiver_bench
